// file: common/dmacc_consts.svh
// constants for the dma channel controller and its data mover engines
`ifndef DMACC_CONSTS_SVH
`define DMACC_CONSTS_SVH
`define DMACC_NDMA 4
`define DMACC_NQDMA 8
`define DMACC_NCH 12
`define DMACC_NQ 2
`define DMACC_QDEPTH 16
`define DMACC_QAW 4
`define DMACC_NSET 16
`define DMACC_PM_WORDS 128
`define DMACC_WCTX_DEPTH 2
`define DMACC_WCTX_AW 1
`define DMACC_DFIFO_DEPTH 8
`define DMACC_DFIFO_AW 3
`define DMACC_WR_MIN_WORDS 1
`define DMACC_WORD_BYTES 32'h0000_0004
`define DMACC_PM_SEL 3'h1
`define DMACC_OFS_EVT 12'h000
`define DMACC_OFS_ESR 12'h004
`define DMACC_OFS_MISS 12'h008
`define DMACC_OFS_ERR 12'h00c
`define DMACC_OFS_COMP 12'h010
`define DMACC_OFS_ACTIVE 12'h014
`define DMACC_OFS_QSTAT 12'h018
`define DMACC_OFS_QTHR 12'h01c
`define DMACC_OFS_DCFG 12'h020
`define DMACC_MASK_DCFG 12'hff0
`define DMACC_OFS_QMAP 12'h040
`define DMACC_MASK_QMAP 12'hfe0
`define DMACC_OFS_RCFG 12'h060
`define DMACC_OFS_RESR 12'h068
`define DMACC_MASK_REG2 12'hff8
`define DMACC_W_OPT 3'h0
`define DMACC_W_SRC 3'h1
`define DMACC_W_AB 3'h2
`define DMACC_W_DST 3'h3
`define DMACC_W_CCNT 3'h7
`define DMACC_OPT_EARLY 0
`define DMACC_OPT_INTR 1
`define DMACC_OPT_CHAIN 2
`define DMACC_OPT_TCC_LO 4
`define DMACC_THR_RESET 5'h10
`endif

// file: common/dmacc_pkg.sv
// types shared by the channel controller and the data mover engines
package dmacc_pkg;
  typedef struct packed {
    logic report;
    logic intr;
    logic chain;
    logic [1:0] tcc;
  } dmacc_code_t;
  typedef struct packed {
    logic [31:0] src;
    logic [31:0] dst;
    logic [14:0] nwords;
    dmacc_code_t code;
  } dmacc_cmd_t;
  typedef struct packed {
    logic quick;
    logic [2:0] chan;
  } dmacc_qent_t;
endpackage

// file: rtl/dmacc_engine.sv
// data mover engine: program set, source active set, write contexts, data fifo
`timescale 1ns/1ps
`include "dmacc_consts.svh"
module dmacc_engine (
  input wire logic ref_clk,
  input wire logic rst,
  input wire dmacc_pkg::dmacc_cmd_t cmd,
  input wire logic cmd_valid,
  output logic cmd_ready,
  output logic rd_req,
  output logic [31:0] rd_addr,
  input wire logic rd_ack,
  input wire logic [31:0] rd_data,
  output logic wr_req,
  output logic [31:0] wr_addr,
  output logic [31:0] wr_data,
  input wire logic wr_ack,
  output logic done_valid,
  output dmacc_pkg::dmacc_code_t done_code,
  output logic busy
);
  import dmacc_pkg::*;
  localparam logic [`DMACC_WCTX_AW:0] WFULL = (`DMACC_WCTX_AW+1)'(`DMACC_WCTX_DEPTH);
  localparam logic [`DMACC_DFIFO_AW:0] DFULL = (`DMACC_DFIFO_AW+1)'(`DMACC_DFIFO_DEPTH);
  localparam logic [`DMACC_DFIFO_AW:0] WMIN = (`DMACC_DFIFO_AW+1)'(`DMACC_WR_MIN_WORDS);
  dmacc_cmd_t prog_reg;
  logic prog_v_reg;
  logic [31:0] src_reg;
  logic [14:0] src_left_reg;
  dmacc_cmd_t wctx_reg [`DMACC_WCTX_DEPTH];
  logic [`DMACC_WCTX_AW-1:0] wctx_wp_reg, wctx_rp_reg;
  logic [`DMACC_WCTX_AW:0] wctx_cnt_reg;
  logic [31:0] dfifo_reg [`DMACC_DFIFO_DEPTH];
  logic [`DMACC_DFIFO_AW-1:0] dfifo_wp_reg, dfifo_rp_reg;
  logic [`DMACC_DFIFO_AW:0] dfifo_cnt_reg;
  logic done_valid_reg;
  dmacc_code_t done_code_reg;
  // ==========================================================
  // handshake and controller decisions
  dmacc_cmd_t whead;
  assign whead = wctx_reg[wctx_rp_reg];
  wire take = cmd_valid & cmd_ready;
  wire wctx_full = wctx_cnt_reg == WFULL;
  wire wctx_ne = wctx_cnt_reg != '0;
  wire load = prog_v_reg & (src_left_reg == '0) & ~wctx_full;
  wire wpop = wctx_ne & (whead.nwords == '0);
  wire rd_take = rd_req & rd_ack;
  wire wr_take = wr_req & wr_ack;
  assign cmd_ready = ~prog_v_reg; // RULE25
  assign rd_req = (src_left_reg != '0) & (dfifo_cnt_reg < DFULL); // RULE15
  assign rd_addr = src_reg;
  assign wr_req = wctx_ne & (whead.nwords != '0) & (dfifo_cnt_reg >= WMIN); // RULE16
  assign wr_addr = whead.dst;
  assign wr_data = dfifo_reg[dfifo_rp_reg];
  assign done_valid = done_valid_reg;
  assign done_code = done_code_reg;
  assign busy = prog_v_reg | (src_left_reg != '0) | wctx_ne;
  // ==========================================================
  // program set and source active set
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prog_v_reg <= 1'b0;
      prog_reg <= '0;
      src_reg <= 32'h0000_0000;
      src_left_reg <= '0;
    end else begin
      if (take) begin
        prog_reg <= cmd;
      end
      prog_v_reg <= take | (prog_v_reg & ~load);
      if (load) begin
        src_reg <= prog_reg.src; // RULE13 RULE14
        src_left_reg <= prog_reg.nwords;
      end else if (rd_take) begin
        src_reg <= src_reg + `DMACC_WORD_BYTES;
        src_left_reg <= src_left_reg - 15'h0001;
      end
    end
  end
  // ==========================================================
  // write context fifo, up to depth requests ahead of the writer
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wctx_wp_reg <= '0;
      wctx_rp_reg <= '0;
      wctx_cnt_reg <= '0;
      for (int i = 0; i < `DMACC_WCTX_DEPTH; i++) begin
        wctx_reg[i] <= '0;
      end
      done_valid_reg <= 1'b0;
      done_code_reg <= '0;
    end else begin
      if (load) begin
        wctx_reg[wctx_wp_reg] <= prog_reg; // RULE17
        wctx_wp_reg <= wctx_wp_reg + 1'b1;
      end
      if (wr_take) begin
        wctx_reg[wctx_rp_reg].dst <= whead.dst + `DMACC_WORD_BYTES;
        wctx_reg[wctx_rp_reg].nwords <= whead.nwords - 15'h0001;
      end
      if (wpop) begin
        wctx_rp_reg <= wctx_rp_reg + 1'b1;
      end
      wctx_cnt_reg <= wctx_cnt_reg + {{`DMACC_WCTX_AW{1'b0}}, load} - {{`DMACC_WCTX_AW{1'b0}}, wpop};
      done_valid_reg <= wpop; // RULE18
      done_code_reg <= wpop ? whead.code : done_code_reg;
    end
  end
  // ==========================================================
  // data fifo
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dfifo_wp_reg <= '0;
      dfifo_rp_reg <= '0;
      dfifo_cnt_reg <= '0;
      for (int i = 0; i < `DMACC_DFIFO_DEPTH; i++) begin
        dfifo_reg[i] <= 32'h0000_0000;
      end
    end else begin
      if (rd_take) begin
        dfifo_reg[dfifo_wp_reg] <= rd_data;
        dfifo_wp_reg <= dfifo_wp_reg + 1'b1;
      end
      if (wr_take) begin
        dfifo_rp_reg <= dfifo_rp_reg + 1'b1;
      end
      dfifo_cnt_reg <= dfifo_cnt_reg + {{`DMACC_DFIFO_AW{1'b0}}, rd_take}
        - {{`DMACC_DFIFO_AW{1'b0}}, wr_take};
    end
  end
  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_prog_stall: assert property (take |=> prog_v_reg && !cmd_ready) // RULE25
    else $error("program set accepted a second request");
  a_idle_move: assert property (take && !busy |-> ##2 (wctx_cnt_reg != '0 && !prog_v_reg)) // RULE13
    else $error("first request not moved to active and write context");
  a_second_wait: assert property (prog_v_reg && src_left_reg != '0 |=> prog_v_reg) // RULE14
    else $error("program set left before source exhausted");
  a_read_room: assert property (rd_req |-> dfifo_cnt_reg < DFULL) // RULE15
    else $error("read issued without data fifo room");
  a_write_data: assert property (wr_req |-> dfifo_cnt_reg >= WMIN) // RULE16
    else $error("write issued without data");
  a_wctx_depth: assert property (wctx_cnt_reg <= WFULL) // RULE17
    else $error("write context overflow");
  a_done_code: assert property (wpop |=> done_valid && done_code == $past(whead.code)) // RULE18
    else $error("completion code missing");
endmodule

// file: rtl/dmacc_top.sv
// dma channel controller: triggers, event queues, parameter memory, apb registers
`timescale 1ns/1ps
`include "dmacc_consts.svh"
// Function
// RULE1: each event queue holds at most sixteen
// RULE2: trigger to full queue waits, never dropped
// RULE3: dma channels queue ahead of quick channels
// RULE4: lowest channel number wins within group
// RULE5: queues serviced in order, head reads set
// RULE6: only valid requests go, queue k engine k
// RULE7: dma trigger: pin event, software, chaining
// RULE8: quick channel fires on its trigger word
// RULE9: trigger logged in event status first
// RULE10: software maps channel queue and set
// RULE11: completion at end or early on submit
// RULE12: error interrupt on misses and thresholds
// RULE13: idle engine moves first request immediately
// RULE14: second request waits until source exhausted
// RULE15: reads only with data fifo room
// RULE16: writes start once enough data buffered
// RULE17: write contexts bound read run ahead
// RULE18: engine returns completion code for events
// RULE19: region registers own channels and interrupts
// RULE20: debug registers show queues, activity, misses
// RULE21: parameter set is eight 32-bit words
// RULE22: eight quick channels on trigger words
// RULE23: all zero counts is null transfer error
// RULE24: retrigger of pending channel flags miss
// RULE25: submission stalls while program set busy
module dmacc_top (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] ext_evt,
  output logic [1:0] rd_req,
  output logic [1:0][31:0] rd_addr,
  input wire logic [1:0] rd_ack,
  input wire logic [1:0][31:0] rd_data,
  output logic [1:0] wr_req,
  output logic [1:0][31:0] wr_addr,
  output logic [1:0][31:0] wr_data,
  input wire logic [1:0] wr_ack,
  output logic err_irq,
  output logic [1:0] done_irq
);
  import dmacc_pkg::*;
  localparam logic [`DMACC_QAW:0] QFULL = (`DMACC_QAW+1)'(`DMACC_QDEPTH);
  logic [`DMACC_NCH-1:0] evt_reg, miss_reg;
  logic [2:0] err_reg;
  logic [`DMACC_NDMA-1:0] comp_reg;
  logic [4:0] thr_reg [`DMACC_NQ];
  logic [4:0] dcfg_reg [`DMACC_NDMA];
  logic [7:0] qmap_reg [`DMACC_NQDMA];
  logic [15:0] region_reg [2];
  logic [31:0] pm_reg [`DMACC_PM_WORDS];
  logic [31:0] prdata_reg;
  logic [3:0] ext_s1_reg, ext_s2_reg, ext_s3_reg, ext_lvl_reg;
  dmacc_qent_t qmem_reg [`DMACC_NQ][`DMACC_QDEPTH];
  logic [`DMACC_QAW-1:0] q_wp_reg [`DMACC_NQ];
  logic [`DMACC_QAW-1:0] q_rp_reg [`DMACC_NQ];
  logic [`DMACC_QAW:0] q_cnt_reg [`DMACC_NQ];
  // ==========================================================
  // apb decode
  wire apb_setup = psel & ~penable;
  wire apb_wr = psel & penable & pwrite;
  wire [11:0] ofs = {paddr[11:2], 2'b00};
  wire pm_hit = paddr[11:9] == `DMACC_PM_SEL;
  wire [6:0] pm_idx = paddr[8:2]; // RULE21
  wire [3:0] pm_set = paddr[8:5];
  wire [2:0] pm_word = paddr[4:2];
  wire dcfg_hit = (ofs & `DMACC_MASK_DCFG) == `DMACC_OFS_DCFG;
  wire qmap_hit = (ofs & `DMACC_MASK_QMAP) == `DMACC_OFS_QMAP;
  wire rcfg_hit = (ofs & `DMACC_MASK_REG2) == `DMACC_OFS_RCFG;
  wire resr_hit = (ofs & `DMACC_MASK_REG2) == `DMACC_OFS_RESR;
  wire low_hit = (ofs == `DMACC_OFS_EVT) | (ofs == `DMACC_OFS_ESR) | (ofs == `DMACC_OFS_MISS)
    | (ofs == `DMACC_OFS_ERR) | (ofs == `DMACC_OFS_COMP) | (ofs == `DMACC_OFS_ACTIVE)
    | (ofs == `DMACC_OFS_QSTAT) | (ofs == `DMACC_OFS_QTHR);
  wire any_hit = pm_hit | dcfg_hit | qmap_hit | rcfg_hit | resr_hit | low_hit;
  wire wr_ok = apb_wr & any_hit;
  wire wr_esr = wr_ok & (ofs == `DMACC_OFS_ESR);
  wire wr_miss = wr_ok & (ofs == `DMACC_OFS_MISS);
  wire wr_err = wr_ok & (ofs == `DMACC_OFS_ERR);
  wire wr_comp = wr_ok & (ofs == `DMACC_OFS_COMP);
  wire wr_thr = wr_ok & (ofs == `DMACC_OFS_QTHR);
  wire wr_pm = wr_ok & pm_hit;
  wire [`DMACC_NQ-1:0] eng_busy, cmd_valid, cmd_ready, q_pop, q_push, q_null, q_full, early;
  logic [`DMACC_NDMA-1:0] comp_set, chain_trig;
  // ==========================================================
  // trigger sources
  wire [3:0] ext_agree = ~(ext_s2_reg ^ ext_s3_reg);
  wire [3:0] ext_lvl_next = (ext_s3_reg & ext_agree) | (ext_lvl_reg & ~ext_agree);
  wire [3:0] ext_rise = ext_lvl_next & ~ext_lvl_reg;
  wire [3:0] region_set = (wr_ok & resr_hit) ? (pwdata[3:0] & region_reg[ofs[2]][3:0]) : 4'h0;
  wire [3:0] sw_set = wr_esr ? pwdata[3:0] : 4'h0;
  wire [3:0] dma_trig = ext_rise | sw_set | region_set | chain_trig; // RULE7 RULE19
  logic [`DMACC_NQDMA-1:0] q_trig;
  logic [`DMACC_NCH-1:0] ch_q;
  logic [3:0] ch_set [`DMACC_NCH];
  genvar gc;
  for (gc = 0; gc < `DMACC_NDMA; gc++) begin : g_dma
    assign ch_q[gc] = dcfg_reg[gc][4]; // RULE10
    assign ch_set[gc] = dcfg_reg[gc][3:0];
  end
  for (gc = 0; gc < `DMACC_NQDMA; gc++) begin : g_quick_trigger_channel
    assign q_trig[gc] = wr_pm & (pm_set == qmap_reg[gc][3:0])
      & (pm_word == qmap_reg[gc][6:4]); // RULE8 RULE22
    assign ch_q[`DMACC_NDMA+gc] = qmap_reg[gc][7]; // RULE10
    assign ch_set[`DMACC_NDMA+gc] = qmap_reg[gc][3:0];
  end
  wire [`DMACC_NCH-1:0] trig = {q_trig, dma_trig};
  // ==========================================================
  // arbitration into event queues
  function automatic logic [3:0] oh_idx(input logic [`DMACC_NCH-1:0] oh);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < `DMACC_NCH; i++) begin
      if (oh[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction
  logic [`DMACC_NCH-1:0] blocked;
  for (gc = 0; gc < `DMACC_NCH; gc++) begin : g_blk
    assign blocked[gc] = q_full[ch_q[gc]]; // RULE2
  end
  wire [`DMACC_NCH-1:0] elig = evt_reg & ~blocked;
  wire [`DMACC_NCH-1:0] enq_oh = elig & (~elig + 12'h001); // RULE3 RULE4
  wire enq_any = |elig;
  wire [3:0] enq_idx = oh_idx(enq_oh);
  wire [3:0] enq_sub = enq_idx - 4'h4;
  wire enq_quick = enq_idx >= 4'h4;
  dmacc_qent_t enq_ent;
  assign enq_ent.quick = enq_quick;
  assign enq_ent.chan = enq_quick ? enq_sub[2:0] : enq_idx[2:0];
  wire enq_q = ch_q[enq_idx];
  wire [`DMACC_NCH-1:0] miss_hit = trig & evt_reg & ~enq_oh; // RULE24
  wire [`DMACC_NCH-1:0] evt_next = (evt_reg & ~enq_oh) | trig; // RULE9
  wire [`DMACC_NCH-1:0] miss_next = (miss_reg & ~(wr_miss ? pwdata[11:0] : 12'h000)) | miss_hit;
  // ==========================================================
  // per queue submission and engines
  dmacc_code_t sub_code [`DMACC_NQ];
  dmacc_code_t done_code [`DMACC_NQ];
  wire [`DMACC_NQ-1:0] done_valid;
  genvar gq;
  for (gq = 0; gq < `DMACC_NQ; gq++) begin : g_q
    dmacc_qent_t head;
    dmacc_cmd_t cmd;
    assign head = qmem_reg[gq][q_rp_reg[gq]];
    wire [3:0] hidx = head.quick ? {1'b0, head.chan} + 4'h4 : {1'b0, head.chan};
    wire [3:0] hset = ch_set[hidx]; // RULE5
    wire [31:0] opt = pm_reg[{hset, `DMACC_W_OPT}];
    wire [31:0] ab = pm_reg[{hset, `DMACC_W_AB}];
    wire [15:0] ccnt = pm_reg[{hset, `DMACC_W_CCNT}][15:0];
    wire nonempty = q_cnt_reg[gq] != '0;
    assign q_full[gq] = q_cnt_reg[gq] == QFULL;
    assign q_push[gq] = enq_any & (enq_q == 1'(gq));
    assign q_null[gq] = (ab == 32'h0000_0000) & (ccnt == 16'h0000); // RULE23
    assign cmd_valid[gq] = nonempty & ~q_null[gq]; // RULE6
    assign q_pop[gq] = nonempty & (q_null[gq] | cmd_ready[gq]); // RULE5 RULE25
    assign early[gq] = cmd_valid[gq] & cmd_ready[gq] & opt[`DMACC_OPT_EARLY]; // RULE11
    assign sub_code[gq].report = ~opt[`DMACC_OPT_EARLY];
    assign sub_code[gq].intr = opt[`DMACC_OPT_INTR];
    assign sub_code[gq].chain = opt[`DMACC_OPT_CHAIN];
    assign sub_code[gq].tcc = opt[`DMACC_OPT_TCC_LO+1:`DMACC_OPT_TCC_LO];
    assign cmd.src = pm_reg[{hset, `DMACC_W_SRC}];
    assign cmd.dst = pm_reg[{hset, `DMACC_W_DST}];
    assign cmd.nwords = {1'b0, ab[15:2]} + {14'h0000, |ab[1:0]};
    assign cmd.code = sub_code[gq];
    dmacc_engine u_eng ( // RULE6
      .ref_clk(ref_clk),
      .rst(rst),
      .cmd(cmd),
      .cmd_valid(cmd_valid[gq]),
      .cmd_ready(cmd_ready[gq]),
      .rd_req(rd_req[gq]),
      .rd_addr(rd_addr[gq]),
      .rd_ack(rd_ack[gq]),
      .rd_data(rd_data[gq]),
      .wr_req(wr_req[gq]),
      .wr_addr(wr_addr[gq]),
      .wr_data(wr_data[gq]),
      .wr_ack(wr_ack[gq]),
      .done_valid(done_valid[gq]),
      .done_code(done_code[gq]),
      .busy(eng_busy[gq])
    );
  end
  // ==========================================================
  // completion detection
  always_comb begin
    comp_set = '0;
    chain_trig = '0;
    for (int q = 0; q < `DMACC_NQ; q++) begin
      if (done_valid[q] && done_code[q].report) begin // RULE18 RULE11
        comp_set[done_code[q].tcc] = comp_set[done_code[q].tcc] | done_code[q].intr;
        chain_trig[done_code[q].tcc] = chain_trig[done_code[q].tcc] | done_code[q].chain;
      end
      if (early[q]) begin
        comp_set[sub_code[q].tcc] = comp_set[sub_code[q].tcc] | sub_code[q].intr;
        chain_trig[sub_code[q].tcc] = chain_trig[sub_code[q].tcc] | sub_code[q].chain;
      end
    end
  end
  wire [1:0] thr_hit = {q_cnt_reg[1] > thr_reg[1], q_cnt_reg[0] > thr_reg[0]};
  wire [2:0] err_set = {thr_hit, |(q_pop & q_null)};
  wire [2:0] err_next = (err_reg & ~(wr_err ? pwdata[2:0] : 3'h0)) | err_set;
  wire [3:0] comp_next = (comp_reg & ~(wr_comp ? pwdata[3:0] : 4'h0)) | comp_set;
  assign err_irq = (|miss_reg) | (|err_reg); // RULE12
  assign done_irq[0] = |(comp_reg & region_reg[0][15:12]); // RULE19
  assign done_irq[1] = |(comp_reg & region_reg[1][15:12]);
  // ==========================================================
  // read mux
  wire [31:0] active_word = {28'h000_0000, eng_busy, |cmd_valid, |evt_reg};
  wire [31:0] qstat_word = {19'h0_0000, q_cnt_reg[1], 3'h0, q_cnt_reg[0]};
  wire [31:0] rd_mux = pm_hit ? pm_reg[pm_idx]
    : dcfg_hit ? {27'h000_0000, dcfg_reg[ofs[3:2]]}
    : qmap_hit ? {24'h00_0000, qmap_reg[ofs[4:2]]}
    : rcfg_hit ? {16'h0000, region_reg[ofs[2]]}
    : (ofs == `DMACC_OFS_EVT) ? {20'h0_0000, evt_reg}
    : (ofs == `DMACC_OFS_MISS) ? {20'h0_0000, miss_reg} // RULE20
    : (ofs == `DMACC_OFS_ERR) ? {29'h0000_0000, err_reg}
    : (ofs == `DMACC_OFS_COMP) ? {28'h000_0000, comp_reg}
    : (ofs == `DMACC_OFS_ACTIVE) ? active_word // RULE20
    : (ofs == `DMACC_OFS_QSTAT) ? qstat_word // RULE20
    : (ofs == `DMACC_OFS_QTHR) ? {19'h0_0000, thr_reg[1], 3'h0, thr_reg[0]}
    : 32'h0000_0000;
  assign prdata = prdata_reg;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~any_hit;
  // ==========================================================
  // registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prdata_reg <= 32'h0000_0000;
      ext_s1_reg <= 4'h0;
      ext_s2_reg <= 4'h0;
      ext_s3_reg <= 4'h0;
      ext_lvl_reg <= 4'h0;
      evt_reg <= '0;
      miss_reg <= '0;
      err_reg <= 3'h0;
      comp_reg <= 4'h0;
    end else begin
      prdata_reg <= apb_setup ? rd_mux : prdata_reg;
      ext_s1_reg <= ext_evt;
      ext_s2_reg <= ext_s1_reg;
      ext_s3_reg <= ext_s2_reg;
      ext_lvl_reg <= ext_lvl_next;
      evt_reg <= evt_next;
      miss_reg <= miss_next;
      err_reg <= err_next;
      comp_reg <= comp_next;
    end
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < `DMACC_NDMA; i++) dcfg_reg[i] <= 5'h00;
      for (int i = 0; i < `DMACC_NQDMA; i++) qmap_reg[i] <= 8'h00;
      for (int i = 0; i < `DMACC_NQ; i++) thr_reg[i] <= `DMACC_THR_RESET;
      for (int i = 0; i < 2; i++) region_reg[i] <= 16'h0000;
      for (int i = 0; i < `DMACC_PM_WORDS; i++) pm_reg[i] <= 32'h0000_0000;
    end else begin
      if (wr_ok & dcfg_hit) dcfg_reg[ofs[3:2]] <= pwdata[4:0];
      if (wr_ok & qmap_hit) qmap_reg[ofs[4:2]] <= pwdata[7:0];
      if (wr_ok & rcfg_hit) region_reg[ofs[2]] <= pwdata[15:0];
      if (wr_thr) begin
        thr_reg[0] <= pwdata[4:0];
        thr_reg[1] <= pwdata[12:8];
      end
      if (wr_pm) pm_reg[pm_idx] <= pwdata;
    end
  end
  // fifo per queue; push and pop in one cycle keep the count
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int q = 0; q < `DMACC_NQ; q++) begin
        q_wp_reg[q] <= '0;
        q_rp_reg[q] <= '0;
        q_cnt_reg[q] <= '0;
        for (int e = 0; e < `DMACC_QDEPTH; e++) qmem_reg[q][e] <= '0;
      end
    end else begin
      for (int q = 0; q < `DMACC_NQ; q++) begin
        if (q_push[q]) begin
          qmem_reg[q][q_wp_reg[q]] <= enq_ent; // RULE10
          q_wp_reg[q] <= q_wp_reg[q] + 1'b1;
        end
        if (q_pop[q]) q_rp_reg[q] <= q_rp_reg[q] + 1'b1; // RULE5
        q_cnt_reg[q] <= q_cnt_reg[q] + {{`DMACC_QAW{1'b0}}, q_push[q]}
          - {{`DMACC_QAW{1'b0}}, q_pop[q]}; // RULE1
      end
    end
  end
  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_queue_depth: assert property (q_cnt_reg[0] <= QFULL && q_cnt_reg[1] <= QFULL) // RULE1
    else $error("event queue above sixteen");
  a_pend_kept: assert property (##1 ((($past(evt_reg) & ~$past(enq_oh)) & ~evt_reg) == '0)) // RULE2
    else $error("pending trigger dropped");
  a_prio_order: assert property (enq_any |-> $onehot(enq_oh) && (elig & (enq_oh - 12'h001)) == '0) // RULE3 RULE4
    else $error("arbitration order wrong");
  a_trig_logged: assert property (##1 ((evt_reg & $past(trig)) == $past(trig))) // RULE9
    else $error("trigger not logged");
  a_missed_set: assert property (##1 ((miss_reg & $past(miss_hit)) == $past(miss_hit))) // RULE24
    else $error("missed event not flagged");
  a_valid_only: assert property (cmd_valid[0] |-> !q_null[0]) // RULE6
    else $error("null request forwarded");
  a_null_err: assert property (|(q_pop & q_null) |=> err_reg[0] && err_irq) // RULE23
    else $error("null transfer not flagged");
  a_err_irq: assert property (miss_reg != '0 |-> err_irq) // RULE12
    else $error("error interrupt missing");
  c_quick_enq: cover property (enq_any && enq_quick);
  c_queue_full: cover property (q_full[0]);
  c_engine_done: cover property (done_valid[0] && done_code[0].chain);
endmodule

// file: sim/dmacc_mem_model.sv
// slave endpoint model answering both engines' read and write requests
`timescale 1ns/1ps
module dmacc_mem_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [1:0] rd_req,
  output logic [1:0] rd_ack,
  output logic [1:0][31:0] rd_data,
  input wire logic [1:0] wr_req,
  output logic [1:0] wr_ack
);
  logic [1:0][31:0] cnt_reg;
  // read data only valid with ack, inverted otherwise
  always_comb begin
    for (int e = 0; e < 2; e++) begin
      rd_data[e] = rd_ack[e] ? 32'h5a00_0000 + cnt_reg[e] : ~(32'h5a00_0000 + cnt_reg[e]);
    end
  end
  // random stalls on both sides
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_ack <= '0;
      wr_ack <= '0;
      cnt_reg <= '0;
    end else begin
      for (int e = 0; e < 2; e++) begin
        rd_ack[e] <= rd_req[e] && !rd_ack[e] && $urandom_range(1, 0);
        wr_ack[e] <= wr_req[e] && !wr_ack[e] && $urandom_range(1, 0);
        if (rd_ack[e]) cnt_reg[e] <= cnt_reg[e] + 32'h0000_0001;
      end
    end
  end
endmodule

// file: sim/dmacc_top_test.sv
// self-checking bench: apb setup, triggered transfers on both engines
`timescale 1ns/1ps
module dmacc_top_test;
  import dmacc_pkg::*;
  logic ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd_v;
  logic pready, pslverr, err_irq, rd_err;
  logic [3:0] ext_evt = '0;
  logic [1:0] rd_req, rd_ack, wr_req, wr_ack, done_irq;
  logic [1:0][31:0] rd_addr, rd_data, wr_addr, wr_data;
  logic [63:0] exp_q [2][$];
  logic [63:0] exp_w;
  int miscompares = 0, samples_checked = 0, cyc = 0;
  always #5 ref_clk = ~ref_clk;
  dmacc_top DUT (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_evt(ext_evt), .rd_req(rd_req), .rd_addr(rd_addr),
    .rd_ack(rd_ack), .rd_data(rd_data), .wr_req(wr_req), .wr_addr(wr_addr),
    .wr_data(wr_data), .wr_ack(wr_ack), .err_irq(err_irq), .done_irq(done_irq));
  dmacc_mem_model mem (.ref_clk(ref_clk), .rst(rst), .rd_req(rd_req), .rd_ack(rd_ack),
    .rd_data(rd_data), .wr_req(wr_req), .wr_ack(wr_ack));
  task automatic check(string name, logic [31:0] exp, logic [31:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic complete_run();
    if (miscompares == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd_v = prdata;
    rd_err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // write data compared in order per engine
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc > 20000) begin
      miscompares++;
      complete_run();
    end
    for (int e = 0; e < 2; e++) begin
      if (wr_req[e] && wr_ack[e] && exp_q[e].size() > 0) begin
        exp_w = exp_q[e].pop_front();
        check("wr_addr", exp_w[63:32], wr_addr[e]);
        check("wr_data", exp_w[31:0], wr_data[e]);
      end else if (wr_req[e] && wr_ack[e]) check("extra write", 32'h0, 32'h1);
    end
  end
  initial begin
    void'($urandom(68));
    repeat (10) @(posedge ref_clk);
    rst <= 0;
    apb(0, 12'h01c, 0);
    check("thr reset", 32'h0000_1010, rd_v);
    apb(0, 12'h100, 0);
    check("unmapped", 32'h0, rd_v);
    check("slverr", 1, rd_err);
    // quick ch0 on set 3 ab word, queue 1; others parked on an unused word
    for (int i = 0; i < 8; i++) apb(1, 12'h040 + 12'(4 * i), (i == 0) ? 32'h0000_00a3 : 32'h0000_007f);
    apb(1, 12'h200, 32'h0000_0002);
    apb(1, 12'h204, $urandom & 32'hffff_fffc);
    apb(1, 12'h208, 32'h0000_0008);
    apb(1, 12'h240, 32'h0000_0012);
    apb(1, 12'h248, 32'h0000_000c);
    apb(1, 12'h24c, 32'h0000_1000);
    apb(1, 12'h024, 32'h0000_0001);
    apb(1, 12'h028, 32'h0000_0012);
    apb(1, 12'h02c, 32'h0000_0013);
    for (int i = 0; i < 2; i++) exp_q[0].push_back({32'(4 * i), 32'h5a00_0000 + 32'(i)});
    for (int i = 0; i < 3; i++) exp_q[1].push_back({32'h0000_1000 + 32'(4 * i), 32'h5a00_0000 + 32'(i)});
    exp_q[1].push_back({32'h0000_0000, 32'h5a00_0003});
    exp_q[1].push_back({32'h0000_0000, 32'h5a00_0004});
    apb(1, 12'h004, 32'h0000_0007);
    apb(1, 12'h268, 32'h0000_0004);
    ext_evt <= 4'h8;
    for (int i = 0; i < 200 && rd_v !== 32'h3; i++) apb(0, 12'h010, 0);
    check("completion", 32'h0000_0003, rd_v);
    apb(0, 12'h00c, 0);
    check("null error", 32'h0000_0001, rd_v & 32'h1);
    check("err_irq", 1, err_irq);
    check("done_irq", 0, done_irq);
    apb(1, 12'h060, 32'h0000_1000);
    repeat (2) @(posedge ref_clk);
    check("done_irq", 1, done_irq);
    apb(1, 12'h010, 32'h0000_0003);
    apb(0, 12'h010, 0);
    check("comp clear", 0, rd_v);
    for (int i = 0; i < 500 && exp_q[0].size() + exp_q[1].size() != 0; i++) @(posedge ref_clk);
    check("queue left", 0, exp_q[0].size() + exp_q[1].size());
    apb(0, 12'h014, 0);
    check("active", 0, rd_v);
    complete_run();
  end
endmodule
